//--- rtl/pwm_timer.sv
// pulse width modulation timer channel with AHB-Lite register slave
// Summary of operation
// - down counter, 16-bit or 8-bit modulator
// - reload on each output rising edge, continuous
// - triggers ignored once counting has begun
// - 16-bit: high n, period 65535
// - 8-bit: high n*(m+1), period 255*(m+1)
// - start by flag, trigger pin or overflow
// - clearing start flag stops counting and pulses
// - interrupt on each output falling edge that ends a high phase by count
// - trigger pin is plain I/O or trigger
// - pulse output pin carries the waveform
// - value register reads back as zero
// - write while stopped loads reload and counter
// - write while counting loads reload only
// - two-bit field selects count source clock
`timescale 1ns/100ps
module pwm_timer
	import pwm_timer_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic trigger_input_pin,
	input wire logic timer_overflow_in,
	input wire logic subclock_div32,
	output logic pulse_output_pin,
	output logic trig_pin_out,
	output logic trig_pin_oe,
	output logic irq
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARMED,
		ST_HIGH,
		ST_LOW
	} pwm_state_e;

	pwm_state_e state_ff;
	pwm_state_e nxt_state;
	logic [CTRL_BITS-1:0] ctrl_ff;
	logic [15:0] reload_ff;
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic [7:0] pre_ff;
	logic [7:0] nxt_pre;
	logic [STAT_BITS-1:0] stat_ff;
	logic [STAT_BITS-1:0] mask_ff;
	logic out_ff;
	logic trig_d_ff;
	logic trig_sw_ff;
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic [31:0] rdata_ff;

	wire logic addr_phase;
	wire logic [7:0] addr_lo;
	wire logic wr_ctrl;
	wire logic wr_value;
	wire logic wr_stat;
	wire logic wr_mask;
	wire logic wr_trig;
	wire logic [31:0] rd_mux;
	wire logic mapped;
	wire logic tick;
	wire logic start_flag;
	wire logic mode8;
	wire logic counting;
	wire logic pin_rise;
	wire logic pin_fall;
	wire logic trig_edge;
	wire logic trig_event;
	wire logic cnt_zero;
	wire logic unit_done;
	wire logic go_high;
	wire logic go_low;
	wire logic [15:0] hi_load;
	wire logic [15:0] lo_load;
	wire logic [7:0] pre_load;
	wire logic rise_evt;
	wire logic fall_evt;
	wire logic [STAT_BITS-1:0] stat_set;
	wire logic [STAT_BITS-1:0] stat_clr;
	wire logic [STAT_BITS-1:0] nxt_stat;
	wire logic [CTRL_BITS-1:0] nxt_ctrl;

	// bus decode: address phase captured, write applied in data phase
	assign addr_phase = hsel && hready && htrans[1];
	assign addr_lo = haddr[7:0];
	assign mapped = (addr_lo == OFS_CTRL) || (addr_lo == OFS_VALUE) ||
		(addr_lo == OFS_STATUS) || (addr_lo == OFS_MASK) || (addr_lo == OFS_TRIG);
	assign wr_ctrl = wr_pend_ff && (wr_addr_ff == OFS_CTRL);
	assign wr_value = wr_pend_ff && (wr_addr_ff == OFS_VALUE);
	assign wr_stat = wr_pend_ff && (wr_addr_ff == OFS_STATUS);
	assign wr_mask = wr_pend_ff && (wr_addr_ff == OFS_MASK);
	assign wr_trig = wr_pend_ff && (wr_addr_ff == OFS_TRIG) && hwdata[0];
	// value register gives no live count back
	assign rd_mux = (addr_lo == OFS_CTRL) ? {23'h0, ctrl_ff} :
		(addr_lo == OFS_VALUE) ? 32'h00000000 :
		(addr_lo == OFS_STATUS) ? {30'h0, stat_ff} :
		(addr_lo == OFS_MASK) ? {30'h0, mask_ff} :
		(addr_lo == OFS_TRIG) ? {31'h0, trigger_input_pin} : 32'h00000000;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_ff;

	// control fields
	assign start_flag = ctrl_ff[CTRL_START];
	assign mode8 = ctrl_ff[CTRL_MODE8];
	assign counting = (state_ff == ST_HIGH) || (state_ff == ST_LOW);

	// trigger pin serves as trigger or as general-purpose port
	assign trig_pin_oe = ctrl_ff[CTRL_PIN_OE] && !ctrl_ff[CTRL_TRIG_EN];
	assign trig_pin_out = ctrl_ff[CTRL_PIN_OUT];
	assign pin_rise = trigger_input_pin && !trig_d_ff;
	assign pin_fall = !trigger_input_pin && trig_d_ff;
	assign trig_edge = ctrl_ff[CTRL_TRIG_RISE] ? pin_rise : pin_fall;
	assign trig_event = ctrl_ff[CTRL_TRIG_OVF] ? (timer_overflow_in || trig_sw_ff) :
		trig_edge;

	count_source_div u_div (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(counting),
		.sel({ctrl_ff[CTRL_SRC_HI], ctrl_ff[CTRL_SRC_LO]}),
		.subclock_div32(subclock_div32),
		.tick(tick)
	);

	// 16-bit: each phase counts source periods; 8-bit: prescaler of m+1
	assign pre_load = reload_ff[7:0];
	assign hi_load = mode8 ? {8'h00, reload_ff[15:8]} : reload_ff;
	assign lo_load = mode8 ? {8'h00, PERIOD8 - reload_ff[15:8]} :
		PERIOD16 - reload_ff;
	assign cnt_zero = (cnt_ff == 16'h0000);
	assign unit_done = tick && (!mode8 || (pre_ff == 8'h00));

	// phase change when the current phase count is exhausted, or on a trigger event while armed
	assign go_high = (state_ff == ST_ARMED && trig_event) ||
		(state_ff == ST_LOW && (cnt_zero || (unit_done && cnt_ff == 16'h0001)) &&
		hi_load != 16'h0000);
	assign go_low = (state_ff == ST_HIGH && (cnt_zero || (unit_done && cnt_ff == 16'h0001))) ||
		(state_ff == ST_LOW && hi_load == 16'h0000 && cnt_zero);
	// every entry into the high phase, including the first one after start
	assign rise_evt = (nxt_state == ST_HIGH) && (state_ff != ST_HIGH);
	assign fall_evt = (state_ff == ST_HIGH) && go_low;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start_flag) begin
					nxt_state = ctrl_ff[CTRL_TRIG_EN] ? ST_ARMED : ST_HIGH;
				end
			end
			ST_ARMED: begin
				if (trig_event) begin
					nxt_state = ST_HIGH;
				end
			end
			ST_HIGH: begin
				if (go_low) begin
					nxt_state = ST_LOW;
				end
			end
			ST_LOW: begin
				// trigger has no effect here, only the count
				if (go_high) begin
					nxt_state = ST_HIGH;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		if (!start_flag) begin
			nxt_state = ST_IDLE;
		end
	end

	// counter: the reload register reaches it at a phase change, and on every cycle while stopped
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_pre = pre_ff;
		if (!start_flag) begin
			nxt_cnt = hi_load;
			nxt_pre = pre_load;
			if (wr_value) begin
				nxt_cnt = mode8 ? {8'h00, hwdata[15:8]} : hwdata[15:0];
				nxt_pre = hwdata[7:0];
			end
		end else if (state_ff == ST_IDLE || state_ff == ST_ARMED) begin
			if (nxt_state == ST_HIGH) begin
				nxt_cnt = hi_load;
				nxt_pre = pre_load;
			end
		end else if (go_high) begin
			nxt_cnt = hi_load;
			nxt_pre = pre_load;
		end else if (go_low) begin
			nxt_cnt = lo_load;
			nxt_pre = pre_load;
		end else if (tick) begin
			if (mode8 && pre_ff != 8'h00) begin
				nxt_pre = pre_ff - 8'h01;
			end else begin
				nxt_pre = pre_load;
				nxt_cnt = cnt_ff - 16'h0001;
			end
		end
	end

	// interrupt status: hardware set wins over write-one-to-clear
	assign stat_set = {rise_evt, fall_evt};
	assign stat_clr = wr_stat ? hwdata[STAT_BITS-1:0] : {STAT_BITS{1'b0}};
	assign nxt_stat = (stat_ff & ~stat_clr) | stat_set;
	assign nxt_ctrl = wr_ctrl ? hwdata[CTRL_BITS-1:0] : ctrl_ff;
	assign irq = |(stat_ff & mask_ff);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			rdata_ff <= 32'h00000000;
		end else begin
			wr_pend_ff <= addr_phase && hwrite && mapped;
			wr_addr_ff <= addr_lo;
			if (addr_phase && !hwrite) begin
				rdata_ff <= rd_mux;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= CTRL_RESET;
			reload_ff <= VALUE_RESET;
			mask_ff <= STAT_RESET;
			stat_ff <= STAT_RESET;
			trig_sw_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			stat_ff <= nxt_stat;
			trig_sw_ff <= wr_trig;
			if (wr_value) begin
				reload_ff <= hwdata[15:0];
			end
			if (wr_mask) begin
				mask_ff <= hwdata[STAT_BITS-1:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= ST_IDLE;
			cnt_ff <= VALUE_RESET;
			pre_ff <= 8'h00;
			out_ff <= 1'b0;
			trig_d_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			pre_ff <= nxt_pre;
			out_ff <= (nxt_state == ST_HIGH);
			trig_d_ff <= trigger_input_pin;
		end
	end

	assign pulse_output_pin = out_ff;
endmodule // pwm_timer

//--- rtl/pwm_timer_pkg.sv
// shared constants for the pulse width modulation timer channel
package pwm_timer_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_VALUE = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0c;
	localparam logic [7:0] OFS_TRIG = 8'h10;
	// control register fields
	localparam int CTRL_START = 0;
	localparam int CTRL_MODE8 = 1;
	localparam int CTRL_TRIG_EN = 2;
	localparam int CTRL_TRIG_OVF = 3;
	localparam int CTRL_TRIG_RISE = 4;
	localparam int CTRL_SRC_LO = 5;
	localparam int CTRL_SRC_HI = 6;
	localparam int CTRL_PIN_OE = 7;
	localparam int CTRL_PIN_OUT = 8;
	localparam int CTRL_BITS = 9;
	localparam logic [CTRL_BITS-1:0] CTRL_RESET = 9'h000;
	// status bit positions
	localparam int STAT_FALL = 0;
	localparam int STAT_RISE = 1;
	localparam int STAT_BITS = 2;
	localparam logic [STAT_BITS-1:0] STAT_RESET = 2'h0;
	localparam logic [15:0] VALUE_RESET = 16'h0000;
	// count source divide ratios
	localparam int DIV_F8 = 8;
	localparam int DIV_F32 = 32;
	localparam int DIV_SUB32 = 32;
	localparam logic [1:0] SRC_F1 = 2'b00;
	localparam logic [1:0] SRC_F8 = 2'b01;
	localparam logic [1:0] SRC_F32 = 2'b10;
	localparam logic [1:0] SRC_SUB = 2'b11;
	// fixed period lengths in counter steps: count-source periods in 16-bit mode, prescaler periods of m+1 in 8-bit mode
	localparam logic [15:0] PERIOD16 = 16'hffff;
	localparam logic [7:0] PERIOD8 = 8'hff;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage

//--- rtl/count_source_div.sv
// count source prescaler: one-cycle tick at the selected rate
`timescale 1ns/100ps
module count_source_div
	import pwm_timer_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic run,
	input wire logic [1:0] sel,
	input wire logic subclock_div32,
	output logic tick
);
	logic [4:0] div_ff;
	logic [4:0] nxt_div;
	logic sub_d_ff;
	logic [4:0] sub_cnt_ff;
	logic [4:0] nxt_sub_cnt;
	wire logic sub_edge;
	wire logic tick8;
	wire logic tick32;
	wire logic tick_sub;

	assign nxt_div = run ? div_ff + 5'h01 : 5'h00;
	assign tick8 = run && (div_ff[2:0] == 3'(DIV_F8 - 1));
	assign tick32 = run && (div_ff == 5'(DIV_F32 - 1));
	// subclock is sampled here; one tick per 32 of its rising edges
	assign sub_edge = subclock_div32 & ~sub_d_ff;
	assign nxt_sub_cnt = !run ? 5'h00 : (sub_edge ? sub_cnt_ff + 5'h01 : sub_cnt_ff);
	assign tick_sub = run && sub_edge && (sub_cnt_ff == 5'(DIV_SUB32 - 1));
	assign tick = (sel == SRC_F1) ? run :
		(sel == SRC_F8) ? tick8 :
		(sel == SRC_F32) ? tick32 : tick_sub;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_ff <= 5'h00;
			sub_d_ff <= 1'b0;
			sub_cnt_ff <= 5'h00;
		end else begin
			div_ff <= nxt_div;
			sub_d_ff <= subclock_div32;
			sub_cnt_ff <= nxt_sub_cnt;
		end
	end
endmodule // count_source_div

//--- verif/pwm_timer_checker.sv
// port assertions for the pwm timer channel
`timescale 1ns/100ps
module pwm_timer_checker
	import pwm_timer_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic pulse_output_pin,
	input wire logic trig_pin_out,
	input wire logic trig_pin_oe,
	input wire logic irq
);
	logic wr_ff;
	logic rd0_ff;
	logic [7:0] adr_ff;
	logic [8:0] ctrl_ff;
	logic [1:0] mask_ff;
	wire take = hsel && hready && htrans[1];
	wire [7:0] a = haddr[7:0];
	// shadow of control and mask, snooped from bus writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ff <= 1'b0;
			rd0_ff <= 1'b0;
			adr_ff <= 8'h00;
			ctrl_ff <= 9'h000;
			mask_ff <= 2'h0;
		end else begin
			wr_ff <= take && hwrite;
			rd0_ff <= take && !hwrite && (a == OFS_VALUE || a > OFS_TRIG);
			adr_ff <= a;
			if (wr_ff && adr_ff == OFS_CTRL) ctrl_ff <= hwdata[8:0];
			if (wr_ff && adr_ff == OFS_MASK) mask_ff <= hwdata[1:0];
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_stop_low: assert property (!ctrl_ff[0] [*2] |-> !pulse_output_pin)
		else $error("pulse while stopped");
	a_rise_started: assert property ($rose(pulse_output_pin) |-> $past(ctrl_ff[0]))
		else $error("pulse rose without start");
	a_irq_fall: assert property ($fell(pulse_output_pin) && ctrl_ff[0] && mask_ff[0]
		|-> ##[0:2] irq)
		else $error("no irq after falling edge");
	a_irq_masked: assert property (mask_ff == 2'h0 [*2] |-> !irq)
		else $error("irq while masked");
	a_irq_hold: assert property (irq && !wr_ff && !$past(wr_ff) |=> irq)
		else $error("irq dropped without write");
	a_rdata_zero: assert property (rd0_ff |-> hrdata == 32'h0)
		else $error("value or unmapped read not zero");
	a_gpio_out: assert property (trig_pin_out == ctrl_ff[8])
		else $error("gpio value wrong");
	a_gpio_oe: assert property (trig_pin_oe == (ctrl_ff[7] && !ctrl_ff[2]))
		else $error("gpio enable wrong");
endmodule // pwm_timer_checker
bind pwm_timer pwm_timer_checker i_pwm_timer_checker (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hrdata, .pulse_output_pin, .trig_pin_out, .trig_pin_oe, .irq);

//--- verif/pwm_load.sv
// load model: measures high time and period of the pulse output
`timescale 1ns/100ps
module pwm_load (
	input wire logic hclk,
	input wire logic pulse_output_pin,
	output int hi_len,
	output int per_len,
	output int falls
);
	int t;
	int t_rise;
	logic last = 1'b0;
	// the waveform on the pin is all the load sees
	always @(posedge hclk) begin
		t <= t + 1;
		last <= pulse_output_pin;
		if (pulse_output_pin && !last) begin
			per_len <= t - t_rise;
			t_rise <= t;
		end
		if (!pulse_output_pin && last) begin
			hi_len <= t - t_rise;
			falls <= falls + 1;
		end
	end
endmodule // pwm_load

//--- verif/tb_top.sv
// self-checking bench for the pwm timer channel
`timescale 1ns/100ps
module tb_top;
	import pwm_timer_pkg::*;
	logic hclk = 0;
	logic hresetn = 0;
	logic hsel = 0;
	logic hwrite = 0;
	logic hready;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic [31:0] q;
	logic hreadyout, hresp, pulse_output_pin, trig_pin_out, trig_pin_oe, irq;
	logic trigger_input_pin = 0;
	logic timer_overflow_in = 0;
	logic subclock_div32 = 0;
	int err_total, check_count, hi_len, per_len, falls;
	always #50 hclk = ~hclk;
	always @(posedge hclk) subclock_div32 <= ~subclock_div32;
	assign hready = hreadyout;
	pwm_timer i_pwm_timer (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .trigger_input_pin, .timer_overflow_in,
		.subclock_div32, .pulse_output_pin, .trig_pin_out, .trig_pin_oe, .irq);
	pwm_load i_pwm_load (.hclk, .pulse_output_pin, .hi_len, .per_len, .falls);
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic near(input string nm, input int s, input int e, input int tol);
		chk(nm, (s - e <= tol && e - s <= tol) ? e : s, e);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic fall_wait(input int k);
		int f0;
		f0 = falls;
		for (int i = 0; i < 70000 && falls < f0 + k; i++) @(posedge hclk);
		if (falls < f0 + k) begin
			chk("falls", falls, f0 + k);
			test_done();
		end
	endtask
	// model: high n or n*(m+1), period 65535 or 255*(m+1), in source periods
	task automatic pwm(input logic [8:0] c, input int n, input int m, input int dv);
		bus(1, OFS_VALUE, c[1] ? n << 8 | m : n);
		bus(1, OFS_CTRL, c);
		fall_wait(1);
		near("high", hi_len, (c[1] ? n * (m + 1) : n) * dv, 2 * dv);
		if (c[1] || dv == 1) begin
			fall_wait(1);
			near("period", per_len, (c[1] ? 255 * (m + 1) : 65535) * dv, 2 * dv);
		end
	endtask
	task automatic stop;
		bus(1, OFS_CTRL, 0);
		repeat (2) @(posedge hclk);
		chk("stopped", pulse_output_pin, 0);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		int n;
		int m;
		int dv[4] = '{1, 8, 32, 64};
		logic [7:0] ra[4] = '{OFS_STATUS, OFS_MASK, OFS_VALUE, 8'h14};
		void'($urandom(32'h270cde66));
		repeat (16) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		foreach (ra[i]) begin
			bus(0, ra[i], 0);
			chk("reset read", q, 0);
		end
		$display("regs done");
		bus(1, OFS_MASK, 1);
		for (int s = 0; s < 4; s++) begin
			n = 1 + $urandom % 6;
			pwm(9'(s << CTRL_SRC_LO | 1), n, 0, dv[s]);
			@(posedge hclk);
			chk("irq", irq, 1);
			bus(1, OFS_STATUS, 3);
			repeat (2) @(posedge hclk);
			chk("irq clear", irq, 0);
			stop();
		end
		$display("sources done");
		n = 1 + $urandom % 8;
		m = $urandom % 4;
		pwm(9'h003, n, m, 1);
		bus(1, OFS_VALUE, (n + 1) << 8 | m);
		bus(0, OFS_VALUE, 0);
		chk("value read", q, 0);
		fall_wait(2);
		near("new high", hi_len, (n + 1) * (m + 1), 2);
		stop();
		$display("8-bit done");
		bus(1, OFS_VALUE, 2 << 8);
		bus(1, OFS_CTRL, 9'h017);
		repeat (20) @(posedge hclk);
		chk("armed", {pulse_output_pin, trig_pin_oe}, 0);
		trigger_input_pin <= 1;
		fall_wait(1);
		trigger_input_pin <= 0;
		repeat (100) @(posedge hclk);
		trigger_input_pin <= 1;
		fall_wait(1);
		near("retrigger", per_len, 255, 2);
		stop();
		bus(1, OFS_VALUE, 5 << 8);
		bus(1, OFS_CTRL, 9'h00f);
		repeat (20) @(posedge hclk);
		chk("ovf armed", pulse_output_pin, 0);
		timer_overflow_in <= 1;
		@(posedge hclk);
		timer_overflow_in <= 0;
		fall_wait(1);
		near("ovf high", hi_len, 5, 2);
		stop();
		bus(1, OFS_VALUE, 8 << 8);
		bus(1, OFS_CTRL, 9'h00f);
		bus(1, OFS_TRIG, 1);
		fall_wait(1);
		near("soft trig", hi_len, 8, 2);
		stop();
		bus(1, OFS_VALUE, 11 << 8);
		bus(1, OFS_CTRL, 9'h007);
		repeat (5) @(posedge hclk);
		chk("fall armed", pulse_output_pin, 0);
		trigger_input_pin <= 0;
		fall_wait(1);
		near("fall trig", hi_len, 11, 2);
		trigger_input_pin <= 1;
		stop();
		bus(1, OFS_CTRL, 9'h180);
		@(posedge hclk);
		chk("gpio", {trig_pin_oe, trig_pin_out}, 2'b11);
		bus(0, OFS_TRIG, 0);
		chk("pin", q[0], 1);
		$display("trigger done");
		test_done();
	end
	initial begin
		repeat (90000) @(posedge hclk);
		err_total++;
		test_done();
	end
endmodule // tb_top
